// ### include/rvc_pkg.sv
// Constants, enumerations and timing counts for the raster controller pins.
// Assumes a 50 MHz system clock; all pin timing is counted in its cycles.
package rvc_pkg;
  localparam int CLK_PERIOD_NS  = 20;
  localparam int RESET_MIN_NS   = 500;
  localparam int RESET_MIN_CYC  =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOST_ACC_NS    = 100;
  localparam int HOST_ACC_CYC   =
    (HOST_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOST_CNT_W     = 4;
  localparam int BUS_W          = 24;
  localparam int LANE_W         = 8;
  localparam int PIX_W          = 64;
  localparam int POS_W          = 12;
  localparam int HADDR_W        = 10;
  localparam int ADDR32_LSB     = 2;
  localparam int ADDR64_LSB     = 3;
  localparam int DEF_LINE_WORDS = 16;
  localparam int DEF_HBLANK_W   = 4;
  localparam int DEF_HSYNC_W    = 2;
  localparam int DEF_FRAME_LN   = 8;
  localparam int DEF_VBLANK_LN  = 2;
  localparam int DEF_VSYNC_LN   = 1;
  localparam int DEF_XFER_POS   = 12;
  localparam logic [23:0] DEF_TOP_ROW = 24'h000000;
  localparam logic [23:0] DEF_ROW_INC = 24'h000001;
  localparam logic [2:0] BPP_1  = 3'h0;
  localparam logic [2:0] BPP_2  = 3'h1;
  localparam logic [2:0] BPP_4  = 3'h2;
  localparam logic [2:0] BPP_8  = 3'h3;
  localparam logic [2:0] BPP_15 = 3'h4;
  localparam logic [2:0] BPP_16 = 3'h5;
  localparam logic [2:0] BPP_24 = 3'h6;
  typedef enum logic [2:0] {
    X_IDLE   = 3'b000,
    X_REQ    = 3'b001,
    X_ADDR   = 3'b010,
    X_STRB_A = 3'b011,
    X_WAITB  = 3'b100,
    X_STRB_B = 3'b101,
    X_DONE   = 3'b110
  } rvc_xfer_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_HOLD = 2'b01,
    H_ACC  = 2'b10,
    H_END  = 2'b11
  } rvc_host_t;
endpackage

// ### verilog/rvc_word_divider.sv
// Divide-by-four phase counter that turns dot ticks into serial words.
// Assumes dot_tick is a one-cycle pulse on clk_sys per dot clock edge used.
`timescale 1ns/100ps
module rvc_word_divider
  import rvc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  input  wire logic       dot_tick,
  output logic [1:0]      phase,
  output logic            word_tick,
  output logic            half_tick
);
  typedef struct packed {
    logic [1:0] phase;
    logic       word_tick;
    logic       half_tick;
  } rvc_div_state_t;

  rvc_div_state_t st;
  rvc_div_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.word_tick = 1'b0;
    next_st.half_tick = 1'b0;
    if (dot_tick) begin
      next_st.phase = st.phase + 2'h1;
      next_st.word_tick = (st.phase == 2'h3);
      next_st.half_tick = (st.phase == 2'h1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign phase = st.phase;
  assign word_tick = st.word_tick;
  assign half_tick = st.half_tick;

  AST_DIV_WRAP: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(word_tick) |-> phase == 2'h0 && $past(phase) == 2'h3)
    else $error("Word tick without a wrap of the phase.");
endmodule

// ### verilog/rvc_pins.sv
// Pin-level core of a raster video controller: timing, VRAM transfer,
// micro port and pixel capture, all run on the 50 MHz system clock.
// Assumes every pin input comes from outside the clock domain.
// What this block does
// - The vertical blank flag is high exactly while a blanked line runs.
// - A transfer raises the DMA request and waits for the grant first.
// - Wait goes high at each host access and stays high until any transfer has ended and its nominal access time has run.
// - Data uses all 24 lines; addresses sit at bit 2 or bit 3 upward.
// - During a transfer the block drives the row address onto the bus.
// - The serial clock runs at one quarter of the dot rate.
// - Interleaved shift clocks run in anti-phase, else only A toggles.
// - Each reload strobe starts on the active edge of its own shift clock.
// - The blanking pin is input or output as the mode input selects.
// - Eight byte lanes form the pixel word, lane a lowest, lane h highest.
// - One pixel word is latched per serial clock period.
// - A shorted loop filter bypasses the multiplier for direct dot clock.
// - The reference clock feeds the multiplier or is the dot clock.
// - Sync pins are outputs in master mode and sampled inputs in slave.
// - Depths of 1, 2, 4, 8, 15, 16 and 24 bits per pixel are supported.
`timescale 1ns/100ps
module rvc_pins
  import rvc_pkg::*;
#(
  parameter int          LINE_WORDS = DEF_LINE_WORDS,
  parameter int          HBLANK_W   = DEF_HBLANK_W,
  parameter int          HSYNC_W    = DEF_HSYNC_W,
  parameter int          FRAME_LN   = DEF_FRAME_LN,
  parameter int          VBLANK_LN  = DEF_VBLANK_LN,
  parameter int          VSYNC_LN   = DEF_VSYNC_LN,
  parameter int          XFER_POS   = DEF_XFER_POS,
  parameter logic [23:0] TOP_ROW    = DEF_TOP_ROW,
  parameter logic [23:0] ROW_INC    = DEF_ROW_INC
)(
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  input  wire logic               clk_en,
  input  wire logic               dot_ref_clock,
  input  wire logic               loop_filter_shorted,
  input  wire logic               times_one_mode,
  input  wire logic               slave_mode,
  input  wire logic               blank_output_mode,
  input  wire logic               interleave_mode,
  input  wire logic               dma_disable,
  input  wire logic               align_64bit,
  input  wire logic [2:0]         bits_per_pixel_code,
  input  wire logic               dma_grant_in,
  input  wire logic               host_read_select,
  input  wire logic               host_output_enable_n,
  input  wire logic               host_select_n,
  input  wire logic [BUS_W-1:0]   muxed_addr_data_in,
  input  wire logic               composite_blank_in,
  input  wire logic               vertical_sync_in_n,
  input  wire logic               composite_or_line_sync_in_n,
  input  wire logic [LANE_W-1:0]  pixel_byte_lane_a,
  input  wire logic [LANE_W-1:0]  pixel_byte_lane_b,
  input  wire logic [LANE_W-1:0]  pixel_byte_lane_c,
  input  wire logic [LANE_W-1:0]  pixel_byte_lane_d,
  input  wire logic [LANE_W-1:0]  pixel_byte_lane_e,
  input  wire logic [LANE_W-1:0]  pixel_byte_lane_f,
  input  wire logic [LANE_W-1:0]  pixel_byte_lane_g,
  input  wire logic [LANE_W-1:0]  pixel_byte_lane_h,
  output logic                    vertical_blank_flag,
  output logic                    dma_request_out,
  output logic                    host_wait,
  output logic [BUS_W-1:0]        muxed_addr_data_out,
  output logic                    muxed_addr_data_oe_n,
  output logic [HADDR_W-1:0]      host_access_addr,
  output logic [BUS_W-1:0]        host_write_data,
  output logic                    host_write_strobe,
  output logic                    pixel_word_clock_n,
  output logic                    vram_shift_clock_a_n,
  output logic                    vram_shift_clock_b_n,
  output logic                    vram_reload_strobe_a,
  output logic                    vram_reload_strobe_b,
  output logic                    composite_blank_out,
  output logic                    composite_blank_oe_n,
  output logic                    vertical_sync_out_n,
  output logic                    composite_or_line_sync_out_n,
  output logic                    sync_oe_n,
  output logic [PIX_W-1:0]        pixel_word,
  output logic                    pixel_word_valid,
  output logic                    pixel_word_blanked,
  output logic [6:0]              pixels_per_word,
  output logic                    dot_clock_direct
);
  localparam logic [POS_W-1:0] LAST_WORD = POS_W'(LINE_WORDS - 1);
  localparam logic [POS_W-1:0] HBL_START = POS_W'(LINE_WORDS - HBLANK_W);
  localparam logic [POS_W-1:0] HSYNC_END = POS_W'(HSYNC_W);
  localparam logic [POS_W-1:0] LAST_LINE = POS_W'(FRAME_LN - 1);
  localparam logic [POS_W-1:0] VBL_END   = POS_W'(VBLANK_LN);
  localparam logic [POS_W-1:0] VSYNC_END = POS_W'(VSYNC_LN);
  localparam logic [POS_W-1:0] XFER_AT   = POS_W'(XFER_POS);
  localparam logic [HOST_CNT_W-1:0] HOST_LAST =
    HOST_CNT_W'(HOST_ACC_CYC - 1);

  typedef struct packed {
    logic [1:0]          ref_s, short_s, vs_s, hs_s, blk_s, gnt_s;
    logic [1:0]          sel_s, rd_s, oe_s;
    logic                ref_d, vs_d, hs_d, sel_d;
    logic [BUS_W-1:0]    bus_s1, bus_s2;
    logic [PIX_W-1:0]    pix_s1, pix_s2;
    logic [POS_W-1:0]    word_pos, line;
    logic                vflag, vsync_n, hsync_n, sync_oe_n, slave;
    logic                blank_out, blank_oe_n, ilv, direct;
    logic                pclk_n, shift_a_n, shift_b_n;
    rvc_xfer_t           xst;
    logic                dma_req, strobe_a, strobe_b;
    logic [BUS_W-1:0]    row;
    rvc_host_t           hst;
    logic [HOST_CNT_W-1:0] hcnt;
    logic                wait_o, hwr, hstrobe;
    logic [HADDR_W-1:0]  haddr;
    logic [BUS_W-1:0]    hwdata, bus_out;
    logic                bus_oe_n;
    logic [PIX_W-1:0]    pix_word;
    logic                pix_valid, pix_blank;
    logic [6:0]          ppw;
  } rvc_top_state_t;

  rvc_top_state_t st;
  rvc_top_state_t next_st;
  logic [1:0]     div_phase;
  logic           word_tick;
  logic           half_tick;
  logic           dot_tick;
  logic           ref_rise;
  logic           ref_fall;

  // Pixels held by one 64-bit word; the 15- and 24-bit modes pad each pixel.
  function automatic logic [6:0] pixels_in_word(input logic [2:0] code);
    case (code)
      BPP_1:   pixels_in_word = 7'h40;
      BPP_2:   pixels_in_word = 7'h20;
      BPP_4:   pixels_in_word = 7'h10;
      BPP_8:   pixels_in_word = 7'h08;
      BPP_15:  pixels_in_word = 7'h04;
      BPP_16:  pixels_in_word = 7'h04;
      BPP_24:  pixels_in_word = 7'h02;
      default: pixels_in_word = 7'h00;
    endcase
  endfunction

  assign ref_rise = st.ref_s[1] & ~st.ref_d;
  assign ref_fall = ~st.ref_s[1] & st.ref_d;
  // The multiplier doubles the reference; direct mode uses rising edges.
  assign dot_tick = st.direct ? ref_rise : (ref_rise | ref_fall);

  rvc_word_divider u_div (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .dot_tick  (dot_tick),
    .phase     (div_phase),
    .word_tick (word_tick),
    .half_tick (half_tick)
  );

  always_comb begin
    next_st = st;
    next_st.ref_s   = {st.ref_s[0], dot_ref_clock};
    next_st.short_s = {st.short_s[0], loop_filter_shorted};
    next_st.vs_s    = {st.vs_s[0], vertical_sync_in_n};
    next_st.hs_s    = {st.hs_s[0], composite_or_line_sync_in_n};
    next_st.blk_s   = {st.blk_s[0], composite_blank_in};
    next_st.gnt_s   = {st.gnt_s[0], dma_grant_in};
    next_st.sel_s   = {st.sel_s[0], host_select_n};
    next_st.rd_s    = {st.rd_s[0], host_read_select};
    next_st.oe_s    = {st.oe_s[0], host_output_enable_n};
    next_st.ref_d   = st.ref_s[1];
    next_st.vs_d    = st.vs_s[1];
    next_st.hs_d    = st.hs_s[1];
    next_st.sel_d   = st.sel_s[1];
    next_st.bus_s1  = muxed_addr_data_in;
    next_st.bus_s2  = st.bus_s1;
    next_st.pix_s1  = {pixel_byte_lane_h, pixel_byte_lane_g,
                       pixel_byte_lane_f, pixel_byte_lane_e,
                       pixel_byte_lane_d, pixel_byte_lane_c,
                       pixel_byte_lane_b, pixel_byte_lane_a};
    next_st.pix_s2  = st.pix_s1;
    next_st.direct  = st.short_s[1] | times_one_mode;
    next_st.ilv     = interleave_mode;
    next_st.slave   = slave_mode;
    next_st.ppw     = pixels_in_word(bits_per_pixel_code);

    // Screen position in serial words; slave mode follows the sync pins.
    if (word_tick) begin
      if (st.word_pos == LAST_WORD) begin
        next_st.word_pos = '0;
        next_st.line = (st.line == LAST_LINE) ? '0 : st.line + 1'b1;
      end else begin
        next_st.word_pos = st.word_pos + 1'b1;
      end
    end
    if (st.slave && st.hs_d && !st.hs_s[1]) begin
      next_st.word_pos = '0;
      next_st.line = st.line + 1'b1;
    end
    if (st.slave && st.vs_d && !st.vs_s[1]) begin
      next_st.line = '0;
    end
    next_st.vflag = (next_st.line < VBL_END);
    next_st.vsync_n = !(next_st.line < VSYNC_END);
    next_st.hsync_n = !(next_st.word_pos < HSYNC_END);
    next_st.sync_oe_n = next_st.slave;
    next_st.blank_out = next_st.vflag || (next_st.word_pos >= HBL_START);
    next_st.blank_oe_n = !blank_output_mode;

    // Serial and shift clocks follow the divider's phase.
    next_st.pclk_n = div_phase[1];
    next_st.shift_a_n = div_phase[1];
    next_st.shift_b_n = next_st.ilv ? ~div_phase[1] : 1'b1;

    // Pixel capture once per serial word, blanking from the chosen source.
    next_st.pix_valid = word_tick;
    if (word_tick) begin
      next_st.pix_word = st.pix_s2;
      next_st.pix_blank = blank_output_mode ? st.blank_out : st.blk_s[1];
    end

    // VRAM shift-register reload sequence.
    case (st.xst)
      X_IDLE: begin
        if (word_tick && st.word_pos == XFER_AT && !dma_disable &&
            !st.vflag) begin
          next_st.xst = X_REQ;
          next_st.dma_req = 1'b1;
        end
      end
      X_REQ: begin
        if (st.gnt_s[1]) begin
          next_st.xst = X_ADDR;
          next_st.bus_out = st.row;
          next_st.bus_oe_n = 1'b0;
        end
      end
      X_ADDR: begin
        if (word_tick) begin
          next_st.xst = X_STRB_A;
          next_st.strobe_a = 1'b1;
        end
      end
      X_STRB_A: begin
        if (word_tick) begin
          next_st.strobe_a = 1'b0;
          next_st.xst = st.ilv ? X_WAITB : X_DONE;
        end
      end
      X_WAITB: begin
        if (half_tick) begin
          next_st.xst = X_STRB_B;
          next_st.strobe_b = 1'b1;
        end
      end
      X_STRB_B: begin
        if (half_tick) begin
          next_st.strobe_b = 1'b0;
          next_st.xst = X_DONE;
        end
      end
      default: begin
        next_st.xst = X_IDLE;
        next_st.dma_req = 1'b0;
        next_st.bus_oe_n = 1'b1;
        next_st.row = st.row + ROW_INC;
      end
    endcase
    if (st.vflag && st.xst == X_IDLE) begin
      next_st.row = TOP_ROW;
    end

    // Micro port access, stretched while a transfer owns the bus.
    next_st.hstrobe = 1'b0;
    case (st.hst)
      H_IDLE: begin
        if (st.sel_d && !st.sel_s[1]) begin
          next_st.hst = H_HOLD;
          next_st.wait_o = 1'b1;
          next_st.hwr = !st.rd_s[1];
          next_st.haddr = align_64bit ?
            st.bus_s2[ADDR64_LSB +: HADDR_W] :
            st.bus_s2[ADDR32_LSB +: HADDR_W];
        end
      end
      H_HOLD: begin
        if (st.xst == X_IDLE) begin
          next_st.hst = H_ACC;
          next_st.hcnt = '0;
        end
      end
      H_ACC: begin
        next_st.hcnt = st.hcnt + 1'b1;
        if (st.hcnt == HOST_LAST) begin
          next_st.hst = H_END;
          next_st.wait_o = 1'b0;
          if (st.hwr) begin
            next_st.hwdata = st.bus_s2;
            next_st.hstrobe = 1'b1;
          end
        end
      end
      default: begin
        if (st.sel_s[1]) begin
          next_st.hst = H_IDLE;
        end
      end
    endcase
    // Host read data may use the bus only while no row address owns it.
    if (next_st.xst == X_IDLE || next_st.xst == X_REQ) begin
      if (st.hst != H_IDLE && !st.hwr && !st.oe_s[1] && !st.sel_s[1]) begin
        next_st.bus_out = {st.line, st.word_pos};
        next_st.bus_oe_n = 1'b0;
      end else if (st.xst == X_IDLE || !st.bus_oe_n) begin
        next_st.bus_oe_n = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= '0;
      st.vs_s <= 2'h3;
      st.hs_s <= 2'h3;
      st.sel_s <= 2'h3;
      st.oe_s <= 2'h3;
      st.vs_d <= 1'b1;
      st.hs_d <= 1'b1;
      st.sel_d <= 1'b1;
      st.vflag <= 1'b1;
      st.vsync_n <= 1'b1;
      st.hsync_n <= 1'b1;
      st.sync_oe_n <= 1'b1;
      st.blank_oe_n <= 1'b1;
      st.pclk_n <= 1'b1;
      st.shift_a_n <= 1'b1;
      st.shift_b_n <= 1'b1;
      st.bus_oe_n <= 1'b1;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign vertical_blank_flag = st.vflag;
  assign dma_request_out = st.dma_req;
  assign host_wait = st.wait_o;
  assign muxed_addr_data_out = st.bus_out;
  assign muxed_addr_data_oe_n = st.bus_oe_n;
  assign host_access_addr = st.haddr;
  assign host_write_data = st.hwdata;
  assign host_write_strobe = st.hstrobe;
  assign pixel_word_clock_n = st.pclk_n;
  assign vram_shift_clock_a_n = st.shift_a_n;
  assign vram_shift_clock_b_n = st.shift_b_n;
  assign vram_reload_strobe_a = st.strobe_a;
  assign vram_reload_strobe_b = st.strobe_b;
  assign composite_blank_out = st.blank_out;
  assign composite_blank_oe_n = st.blank_oe_n;
  assign vertical_sync_out_n = st.vsync_n;
  assign composite_or_line_sync_out_n = st.hsync_n;
  assign sync_oe_n = st.sync_oe_n;
  assign pixel_word = st.pix_word;
  assign pixel_word_valid = st.pix_valid;
  assign pixel_word_blanked = st.pix_blank;
  assign pixels_per_word = st.ppw;
  assign dot_clock_direct = st.direct;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst || !clk_en);

  sequence s_waiting_grant;
    st.xst == X_REQ && !st.gnt_s[1];
  endsequence
  sequence s_host_blocked;
    st.hst == H_HOLD && st.xst != X_IDLE;
  endsequence
  sequence s_host_last;
    st.hst == H_ACC && st.hcnt == HOST_LAST;
  endsequence

  AST_VBLANK_LEVEL: assert property (
    st.vflag == (st.line < VBL_END) && vertical_blank_flag == st.vflag)
    else $error("Vertical blank flag does not match the line count.");
  AST_DMA_GRANT: assert property (
    s_waiting_grant |=> st.xst == X_REQ && !st.strobe_a && st.dma_req)
    else $error("Transfer went ahead without a bus grant.");
  AST_STROBE_REQ: assert property (
    $rose(st.strobe_a) |-> st.dma_req && $past(st.dma_req, 2))
    else $error("Reload strobe issued without a held DMA request.");
  AST_WAIT_HOLD: assert property (
    s_host_blocked |-> st.wait_o ##1 st.wait_o)
    else $error("Wait dropped while a transfer held the bus.");
  AST_WAIT_RELEASE: assert property (
    s_host_last |=> !st.wait_o && st.hst == H_END)
    else $error("Wait not released at the end of the access.");
  AST_XFER_ADDR: assert property (
    (st.strobe_a || st.strobe_b) |-> !st.bus_oe_n && st.bus_out == st.row)
    else $error("Row address not on the bus during a reload.");
  // The fall just after reset starts phase zero and has no word tick.
  AST_SERIAL_CLOCK: assert property (
    ($fell(st.pclk_n) && !$past(sys_rst, 2)) |-> $past(word_tick))
    else $error("Serial clock fell away from a word boundary.");
  AST_SHIFT_PHASE: assert property (
    st.ilv ? (st.shift_b_n != st.shift_a_n) : st.shift_b_n)
    else $error("Shift clock B breaks the interleave setting.");
  AST_STROBE_A_ALIGN: assert property (
    $rose(st.strobe_a) |-> $fell(st.shift_a_n))
    else $error("Reload strobe A not aligned to shift clock A.");
  AST_STROBE_B_ALIGN: assert property (
    $rose(st.strobe_b) |-> $fell(st.shift_b_n) && st.ilv)
    else $error("Reload strobe B not aligned to shift clock B.");
  AST_PIXEL_LATCH: assert property (
    word_tick |=> st.pix_valid && st.pix_word == $past(st.pix_s2))
    else $error("Pixel word not latched on the serial word.");
  AST_SYNC_SLAVE: assert property (
    st.slave |-> st.sync_oe_n ##1 (st.slave || !st.sync_oe_n))
    else $error("Sync pins driven while in slave mode.");
  AST_DIRECT_TICK: assert property (
    (st.direct && dot_tick) |-> st.ref_s[1] && !st.ref_d)
    else $error("Direct dot clock ticked off a reference rise.");
endmodule

// ### tb/rvc_vram_model.sv
// Far side model: VRAM pixel lanes and the host bus arbiter grant.
// Assumes request and grant are levels seen on the rising clk_sys edge.
`timescale 1ns/100ps
module rvc_vram_model (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       dma_request_out,
  input  wire logic [3:0] grant_delay,
  output logic            dma_grant_in,
  output logic [63:0]     lanes
);
  logic [3:0] wait_cnt;
  // Each lane carries its own digit pair so a swapped lane shows at once.
  assign lanes = 64'h8877665544332211;
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !dma_request_out) begin
      wait_cnt     <= 4'h0;
      dma_grant_in <= 1'b0;
    end else if (wait_cnt == grant_delay) begin
      dma_grant_in <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the raster controller pin core.
// Assumes default geometry and a 160 ns reference clock.
`timescale 1ns/100ps
module tb_top;
  import rvc_pkg::*;
  logic clk_sys = 0, sys_rst = 1, clk_en = 1, dot_ref_clock = 0;
  logic loop_filter_shorted = 0, times_one_mode = 0, slave_mode = 0;
  logic blank_output_mode = 0, interleave_mode = 0, dma_disable = 1;
  logic align_64bit = 0, dma_grant_in, host_read_select = 0;
  logic host_output_enable_n = 1, host_select_n = 1, composite_blank_in = 0;
  logic vertical_sync_in_n = 1, composite_or_line_sync_in_n = 1;
  logic vertical_blank_flag, dma_request_out, host_wait, host_write_strobe;
  logic muxed_addr_data_oe_n, pixel_word_clock_n, vram_shift_clock_a_n;
  logic vram_shift_clock_b_n, vram_reload_strobe_a, vram_reload_strobe_b;
  logic composite_blank_out, composite_blank_oe_n, vertical_sync_out_n;
  logic composite_or_line_sync_out_n, sync_oe_n, pixel_word_valid;
  logic pixel_word_blanked, dot_clock_direct, pwc_q, vb_q;
  logic [2:0]  bits_per_pixel_code = 0;
  logic [3:0]  grant_delay = 0;
  logic [6:0]  pixels_per_word;
  logic [9:0]  host_access_addr;
  logic [23:0] muxed_addr_data_out, host_write_data, host_bus = 0, bus_in;
  logic [63:0] pixel_word, lanes;
  int cyc, last_fall, gap, vb_rise, vb_len, bad_count, check_count;
  // The shared bus shows whichever party has its driver enabled.
  assign bus_in = muxed_addr_data_oe_n ? host_bus : muxed_addr_data_out;
  rvc_pins DUT (.*, .muxed_addr_data_in(bus_in),
    .pixel_byte_lane_a(lanes[7:0]), .pixel_byte_lane_b(lanes[15:8]),
    .pixel_byte_lane_c(lanes[23:16]), .pixel_byte_lane_d(lanes[31:24]),
    .pixel_byte_lane_e(lanes[39:32]), .pixel_byte_lane_f(lanes[47:40]),
    .pixel_byte_lane_g(lanes[55:48]), .pixel_byte_lane_h(lanes[63:56]));
  rvc_vram_model u_vram (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .dma_request_out(dma_request_out), .grant_delay(grant_delay),
    .dma_grant_in(dma_grant_in), .lanes(lanes));
  always #10 clk_sys = ~clk_sys;
  initial #3 forever #80 dot_ref_clock = ~dot_ref_clock;
  always @(negedge clk_sys) begin
    cyc++;
    if (pwc_q && !pixel_word_clock_n) begin
      gap = cyc - last_fall;
      last_fall = cyc;
    end
    if (!vb_q && vertical_blank_flag) vb_rise = cyc;
    if (vb_q && !vertical_blank_flag) vb_len = cyc - vb_rise;
    pwc_q = pixel_word_clock_n;
    vb_q = vertical_blank_flag;
    if (cyc == 30000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(ref logic s, input logic v, input int lim);
    int k;
    k = 0;
    while (s !== v && k < lim) begin
      @(negedge clk_sys);
      k++;
    end
    if (s !== v) begin
      bad_count++;
      $display("[ERR] %0t wait ran out", $time);
    end
  endtask
  task automatic do_reset(input logic lf, x1, il);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    loop_filter_shorted <= lf;
    times_one_mode <= x1;
    interleave_mode <= il;
    repeat (RESET_MIN_CYC) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(vertical_blank_flag, 1'b1);
    chk(pixel_word_clock_n, 1'b1);
    @(posedge clk_sys);
    sys_rst <= 1'b0;
  endtask
  task automatic t_clock(input logic lf, x1, il);
    int n, w;
    w = (lf | x1) ? 32 : 16;
    do_reset(lf, x1, il);
    repeat (8 * w) @(negedge clk_sys);
    chk(gap, w);
    chk(dot_clock_direct, lf | x1);
    n = 0;
    for (int i = 0; i < 4 * w; i++) begin
      @(negedge clk_sys);
      n += pixel_word_valid;
      chk(vram_shift_clock_b_n, il ? !vram_shift_clock_a_n : 1'b1);
      if (pixel_word_valid === 1'b1) begin
        chk(pixel_word, lanes);
        chk(pixel_word_blanked, composite_blank_in);
      end
    end
    chk(n, 4);
    $display("test clock done");
  endtask
  task automatic t_dma(input logic [3:0] dl, input logic il);
    logic [23:0] r;
    @(posedge clk_sys);
    grant_delay <= dl;
    interleave_mode <= il;
    dma_disable <= 1'b0;
    wt(vertical_blank_flag, 1'b0, 3000);
    for (int t = 0; t < 2; t++) begin
      wt(dma_request_out, 1'b1, 400);
      wt(muxed_addr_data_oe_n, 1'b0, 40);
      chk(dma_grant_in, 1'b1);
      if (t == 1) chk(muxed_addr_data_out, r + DEF_ROW_INC);
      r = muxed_addr_data_out;
      wt(vram_reload_strobe_a, 1'b1, 40);
      chk(vram_shift_clock_a_n, 1'b0);
      if (il) begin
        wt(vram_reload_strobe_b, 1'b1, 40);
        chk(vram_shift_clock_b_n, 1'b0);
      end
      wt(dma_request_out, 1'b0, 80);
      chk(muxed_addr_data_oe_n, 1'b1);
      chk(vram_reload_strobe_b, 1'b0);
    end
    wt(vertical_blank_flag, 1'b1, 2500);
    chk({composite_blank_out, vertical_sync_out_n,
         composite_or_line_sync_out_n}, 3'b100);
    wt(vertical_blank_flag, 1'b0, 600);
    @(negedge clk_sys);
    chk(vb_len, DEF_VBLANK_LN * DEF_LINE_WORDS * 16);
    @(posedge clk_sys);
    dma_disable <= 1'b1;
    $display("test transfer done");
  endtask
  task automatic t_host(input logic a64, rd);
    logic [23:0] v;
    int n;
    v = 24'hA5C3E7;
    @(posedge clk_sys);
    align_64bit <= a64;
    host_read_select <= rd;
    host_bus <= v;
    @(posedge clk_sys);
    host_select_n <= 1'b0;
    wt(host_wait, 1'b1, 20);
    chk(host_access_addr, a64 ? v[12:3] : v[11:2]);
    n = 0;
    while (host_wait === 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    chk(n, HOST_ACC_CYC + 1);
    if (!rd) chk({host_write_strobe, host_write_data}, {1'b1, v});
    @(posedge clk_sys);
    host_output_enable_n <= ~rd;
    repeat (4) @(negedge clk_sys);
    chk(muxed_addr_data_oe_n, !rd);
    @(posedge clk_sys);
    host_select_n <= 1'b1;
    host_output_enable_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    $display("test host port done");
  endtask
  task automatic t_modes;
    logic [2:0] cd [7] = '{BPP_1, BPP_2, BPP_4, BPP_8, BPP_15, BPP_16,
                           BPP_24};
    int pp [7] = '{64, 32, 16, 8, 4, 4, 2};
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_sys);
      slave_mode <= i[0];
      blank_output_mode <= i[1];
      bits_per_pixel_code <= cd[i];
      repeat (4) @(negedge clk_sys);
      chk(sync_oe_n, i[0]);
      chk(composite_blank_oe_n, !i[1]);
      chk(pixels_per_word, pp[i]);
    end
    $display("test modes done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    t_clock(1'b0, 1'b1, 1'b0);
    t_clock(1'b1, 1'b0, 1'b0);
    t_clock(1'b0, 1'b0, 1'b1);
    t_dma(4'h0, 1'b1);
    t_dma(4'h9, 1'b0);
    t_host(1'b0, 1'b0);
    t_host(1'b1, 1'b1);
    t_modes();
    close_out();
  end
endmodule
